// File: design/ufe_pkg.sv
// constants and types shared by the ipv6 unicast forwarding engine
package ufe_pkg;
	localparam logic       PORT_CUST   = 1'b0;
	localparam logic       PORT_OPER   = 1'b1;
	localparam logic [7:0] NXT_ICMP6   = 8'h3a;
	localparam logic [7:0] T_UNREACH   = 8'h01;
	localparam logic [7:0] T_TOOBIG    = 8'h02;
	localparam logic [7:0] T_TIMEX     = 8'h03;
	localparam logic [7:0] T_PARAM     = 8'h04;
	localparam logic [7:0] T_ECHO_RQ   = 8'h80;
	localparam logic [7:0] T_ECHO_RP   = 8'h81;
	localparam logic [7:0] T_MLQ       = 8'h82;
	localparam logic [7:0] T_MLR       = 8'h83;
	localparam logic [7:0] T_MLD       = 8'h84;
	localparam logic [7:0] T_RS        = 8'h85;
	localparam logic [7:0] T_RA        = 8'h86;
	localparam logic [7:0] T_NS        = 8'h87;
	localparam logic [7:0] T_NA        = 8'h88;
	localparam logic [7:0] T_MLR2      = 8'h8f;
	localparam logic [7:0] C_NO_ROUTE  = 8'h00;
	localparam logic [7:0] C_ADDR_UNR  = 8'h03;
	localparam logic [7:0] C_HOP_EXC   = 8'h00;
	localparam logic [7:0] MC_BYTE     = 8'hff;
	localparam logic [3:0] SCOPE_LINK  = 4'h2;
	localparam logic [7:0] HOP_LAST    = 8'h01;
	localparam logic [7:0] HOP_DEC     = 8'h01;
	localparam int         NC_DEPTH    = 4;
	localparam int         NC_IW       = 2;
	localparam int         Q_DEPTH     = 4;
	localparam int         Q_AW        = 2;
	localparam int         CLK_HZ      = 20_000_000;
	localparam int         RES_TMO_MS  = 1000;
	localparam int         RES_TMO_CYC = CLK_HZ / 1000 * RES_TMO_MS;
	localparam logic       DYN_OPER_RST = 1'b0;

	typedef enum logic [0:0] {ST_IDLE, ST_DECIDE} ufe_state_t;

	typedef struct packed {
		logic         out_port;
		logic         unr_ok;
		logic         rx_port;
		logic [7:0]   hop;
		logic [127:0] nh;
		logic [127:0] src;
		logic [127:0] dst;
	} ufe_qent_t;
endpackage

// File: design/ufe_pend_q.sv
// in-order queue of packets waiting for neighbor resolution
`timescale 1ns/1ps
module ufe_pend_q
	import ufe_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      resetn,
	input  wire logic      push,
	input  wire ufe_qent_t push_data,
	input  wire logic      pop,
	output ufe_qent_t      head,
	output logic           empty,
	output logic           full
);
	ufe_qent_t     mem [Q_DEPTH];
	logic [Q_AW:0] wptr_reg;
	logic [Q_AW:0] rptr_reg;

	assign empty = wptr_reg == rptr_reg;
	assign full  = (wptr_reg[Q_AW] != rptr_reg[Q_AW]) &&
		(wptr_reg[Q_AW-1:0] == rptr_reg[Q_AW-1:0]);
	assign head  = mem[rptr_reg[Q_AW-1:0]];

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wptr_reg <= '0;
			rptr_reg <= '0;
		end
		else
		begin
			if (push && !full)
				wptr_reg <= wptr_reg + 1'b1;
			if (pop && !empty)
				rptr_reg <= rptr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push && !full)
			mem[wptr_reg[Q_AW-1:0]] <= push_data;
	end
endmodule // ufe_pend_q

// File: design/ufe_nbr_cache.sv
// neighbor cache: ipv6 next-hop to link-layer address
`timescale 1ns/1ps
module ufe_nbr_cache
	import ufe_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic [127:0] lk_ip,
	output logic              lk_hit,
	output logic [47:0]       lk_mac,
	input  wire logic         wr_en,
	input  wire logic [127:0] wr_ip,
	input  wire logic [47:0]  wr_mac
);
	logic                vld_reg [NC_DEPTH];
	logic [127:0]        ip_reg  [NC_DEPTH];
	logic [47:0]         mac_reg [NC_DEPTH];
	logic [NC_IW-1:0]    rr_reg;
	logic [NC_DEPTH-1:0] lk_m;
	logic [NC_DEPTH-1:0] wr_m;
	logic [NC_IW-1:0]    lk_idx;
	logic [NC_IW-1:0]    wr_idx;
	logic [NC_IW-1:0]    victim;

	genvar g;
	generate
		for (g = 0; g < NC_DEPTH; g++)
		begin : g_match
			assign lk_m[g] = vld_reg[g] && (ip_reg[g] == lk_ip);
			assign wr_m[g] = vld_reg[g] && (ip_reg[g] == wr_ip);
		end
	endgenerate

	always_comb
	begin
		lk_idx = '0;
		wr_idx = '0;
		for (int i = 0; i < NC_DEPTH; i++)
		begin
			if (lk_m[i])
				lk_idx = NC_IW'(i);
			if (wr_m[i])
				wr_idx = NC_IW'(i);
		end
	end

	assign lk_hit = |lk_m;
	assign lk_mac = mac_reg[lk_idx];
	// an existing entry is refreshed in place, so one ip never has two slots
	assign victim = (|wr_m) ? wr_idx : rr_reg;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rr_reg <= '0;
			for (int i = 0; i < NC_DEPTH; i++)
				vld_reg[i] <= 1'b0;
		end
		else if (wr_en)
		begin
			vld_reg[victim] <= 1'b1;
			if (!(|wr_m))
				rr_reg <= rr_reg + 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			ip_reg[victim]  <= wr_ip;
			mac_reg[victim] <= wr_mac;
		end
	end
endmodule // ufe_nbr_cache

// File: design/ufe_fwd_engine.sv
// per-packet ipv6 forwarding decisions, icmpv6 errors and header rewrite
`timescale 1ns/1ps
// Function
// - packets to an own interface address go to the local stack
// - on-link destination is itself the next-hop
// - off-link uses a router next-hop; none means immediate drop
// - operator-side next-hop is the default router learned from adverts
// - next-hop mac from cache; miss sends solicitation, advert fills cache
// - any error in forwarding discards the packet
// - each drop raises an icmpv6 error naming the reason, unless suppressed; a drop for a full pending queue raises none
// - no error for congestion drops or for dropped icmpv6 errors
// - multicast destination suppresses errors except too-big, param problem
// - no error when destination link-layer address is multicast
// - no error when the source address is unspecified or multicast
// - recognise icmpv6 types 1,3,128-136 and 143
// - no destination unreachable sent out the operator side
// - hop limit decremented on every forwarded packet
// - hop limit zero or reaching zero: drop, time exceeded code 0
// - operator-side egress uses the operator mac as source
// - customer-side egress uses the customer mac as source
// - destination mac is the resolved next-hop mac
// - link-local multicast goes only to the local stack
// - handle router and neighbor solicitations and advertisements
// - no dynamic routing protocol on the operator side by default
// - router adverts only on the customer side, never operator side
// - routing table built at reset, filled from received adverts
module ufe_fwd_engine
	import ufe_pkg::*;
#(
	parameter int RES_TMO = RES_TMO_CYC
)
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic         in_port,
	input  wire logic [127:0] in_dst_ip,
	input  wire logic [127:0] in_src_ip,
	input  wire logic [7:0]   in_hop,
	input  wire logic [7:0]   in_nxt_hdr,
	input  wire logic [7:0]   in_icmp_type,
	input  wire logic         in_l2_mcast,
	input  wire logic         in_congested,
	input  wire logic [127:0] in_nd_target,
	input  wire logic [47:0]  in_nd_mac,
	input  wire logic [127:0] in_ra_prefix,
	input  wire logic [7:0]   in_ra_plen,
	input  wire logic [127:0] cfg_cust_ip,
	input  wire logic [127:0] cfg_oper_ip,
	input  wire logic [127:0] cfg_cust_pfx,
	input  wire logic [7:0]   cfg_cust_plen,
	input  wire logic [47:0]  cfg_cust_mac,
	input  wire logic [47:0]  cfg_oper_mac,
	output logic              loc_valid,
	output logic              loc_port,
	output logic              loc_icmp_known,
	output logic              fwd_valid,
	output logic              fwd_port,
	output logic [127:0]      fwd_dst_ip,
	output logic [47:0]       fwd_dst_mac,
	output logic [47:0]       fwd_src_mac,
	output logic [7:0]        fwd_hop,
	output logic              err_valid,
	output logic              err_port,
	output logic [7:0]        err_type,
	output logic [7:0]        err_code,
	output logic [127:0]      err_dst_ip,
	output logic              ns_valid,
	output logic              ns_port,
	output logic [127:0]      ns_target,
	output logic              ra_tx_cust,
	output logic              drop_valid,
	output logic              dyn_route_oper
);
	function automatic logic is_mcast(input logic [127:0] a);
		return a[127:120] == MC_BYTE;
	endfunction

	function automatic logic pfx_match(input logic [127:0] a,
		input logic [127:0] p, input logic [7:0] len);
		logic [127:0] m;
		m = ~(128'h0 | ({128{1'b1}} >> len));
		return (len != 8'h00) && ((a & m) == (p & m));
	endfunction

	ufe_state_t   st_reg;
	ufe_state_t   st_next;
	logic         r_port;
	logic [127:0] r_dst;
	logic [127:0] r_src;
	logic [7:0]   r_hop;
	logic [7:0]   r_nxt;
	logic [7:0]   r_type;
	logic         r_l2mc;
	logic         r_cong;
	logic [127:0] r_tgt;
	logic [47:0]  r_mac;
	logic [127:0] r_rapfx;
	logic [7:0]   r_raplen;
	logic [127:0] op_pfx_reg;
	logic [7:0]   op_plen_reg;
	logic         op_pfx_vld_reg;
	logic [127:0] def_rtr_reg;
	logic         def_vld_reg;
	logic [31:0]  tmo_reg;
	logic [31:0]  tmo_next;

	// decision terms for the packet under evaluation
	wire own_hit   = (r_dst == cfg_cust_ip) || (r_dst == cfg_oper_ip);
	wire dst_mc    = is_mcast(r_dst);
	wire ll_mc     = dst_mc && (r_dst[115:112] == SCOPE_LINK);
	wire to_local  = own_hit || dst_mc || ll_mc;
	wire cust_on   = pfx_match(r_dst, cfg_cust_pfx, cfg_cust_plen);
	wire oper_on   = op_pfx_vld_reg &&
		pfx_match(r_dst, op_pfx_reg, op_plen_reg);
	wire on_link   = cust_on || oper_on;
	wire route_ok  = on_link || def_vld_reg;
	wire out_port  = cust_on ? PORT_CUST : PORT_OPER;
	wire [127:0] nh = on_link ? r_dst : def_rtr_reg;
	wire hop_exp   = r_hop <= HOP_LAST;
	wire src_bad   = (r_src == 128'h0) || is_mcast(r_src);
	wire err_pkt   = (r_nxt == NXT_ICMP6) && !r_type[7];
	wire is_icmp   = r_nxt == NXT_ICMP6;
	wire known     = is_icmp && ((r_type == T_UNREACH) ||
		(r_type == T_TIMEX) || (r_type == T_ECHO_RQ) ||
		(r_type == T_ECHO_RP) || (r_type == T_MLQ) ||
		(r_type == T_MLR) || (r_type == T_MLD) ||
		(r_type == T_RS) || (r_type == T_RA) ||
		(r_type == T_NS) || (r_type == T_NA) ||
		(r_type == T_MLR2));

	// suppression shared by all error kinds
	wire base_ok   = !err_pkt && !r_l2mc && !src_bad;
	wire timex_ok  = base_ok && !dst_mc;
	wire unr_ok    = base_ok && !dst_mc && (r_port != PORT_OPER);

	// neighbor cache and pending queue
	ufe_qent_t    q_head;
	ufe_qent_t    q_in;
	logic         q_empty;
	logic         q_full;
	logic         nc_hit;
	logic [47:0]  nc_mac;
	wire decide    = st_reg == ST_DECIDE;
	wire [127:0] lk_ip = decide ? nh : q_head.nh;
	wire nd_upd    = decide && to_local && is_icmp &&
		((r_type == T_NA) || (r_type == T_NS)) &&
		(r_tgt != 128'h0);

	// decide-state outcome, in priority order
	wire d_cong    = decide && r_cong;
	wire d_local   = decide && !r_cong && to_local;
	wire d_fwdable = decide && !r_cong && !to_local;
	wire d_hopx    = d_fwdable && hop_exp;
	wire d_noroute = d_fwdable && !hop_exp && !route_ok;
	wire d_try     = d_fwdable && !hop_exp && route_ok;
	wire d_fwd     = d_try && nc_hit;
	wire d_qfull   = d_try && !nc_hit && q_full;
	wire d_enq     = d_try && !nc_hit && !q_full;

	// idle-state service of the pending queue
	wire idle      = st_reg == ST_IDLE;
	wire tmo_hit   = !q_empty && (tmo_reg >= 32'(RES_TMO - 1));
	wire q_drain   = idle && !q_empty && nc_hit;
	wire q_fail    = idle && !q_empty && !nc_hit && tmo_hit;
	wire q_pop     = q_drain || q_fail;

	assign in_ready = idle && !q_pop;
	wire take      = in_valid && in_ready;

	assign q_in.out_port = out_port;
	assign q_in.unr_ok   = unr_ok;
	assign q_in.rx_port  = r_port;
	assign q_in.hop      = r_hop;
	assign q_in.nh       = nh;
	assign q_in.src      = r_src;
	assign q_in.dst      = r_dst;

	ufe_nbr_cache u_cache (
		.clk    (clk),
		.resetn (resetn),
		.lk_ip  (lk_ip),
		.lk_hit (nc_hit),
		.lk_mac (nc_mac),
		.wr_en  (nd_upd),
		.wr_ip  (r_tgt),
		.wr_mac (r_mac)
	);

	ufe_pend_q u_pend (
		.clk       (clk),
		.resetn    (resetn),
		.push      (d_enq),
		.push_data (q_in),
		.pop       (q_pop),
		.head      (q_head),
		.empty     (q_empty),
		.full      (q_full)
	);

	// next values of the registered outputs
	wire any_fwd   = d_fwd || q_drain;
	wire f_port    = d_fwd ? out_port : q_head.out_port;
	wire [7:0] f_hop = (d_fwd ? r_hop : q_head.hop) - HOP_DEC;
	wire [127:0] f_dst = d_fwd ? r_dst : q_head.dst;
	wire [47:0] f_smac = (f_port == PORT_OPER) ?
		cfg_oper_mac : cfg_cust_mac;
	wire e_hopx    = d_hopx && timex_ok;
	wire e_nort    = d_noroute && unr_ok;
	wire e_fail    = q_fail && q_head.unr_ok;
	wire any_err   = e_hopx || e_nort || e_fail;
	wire [7:0] e_type = e_hopx ? T_TIMEX : T_UNREACH;
	wire [7:0] e_code = e_hopx ? C_HOP_EXC :
		(e_fail ? C_ADDR_UNR : C_NO_ROUTE);
	wire [127:0] e_dst = q_fail ? q_head.src : r_src;
	wire e_port    = q_fail ? q_head.rx_port : r_port;
	wire any_drop  = d_cong || d_hopx || d_noroute ||
		d_qfull || q_fail;
	wire rs_cust   = d_local && is_icmp && (r_type == T_RS) &&
		(r_port == PORT_CUST);
	wire ra_learn  = d_local && is_icmp && (r_type == T_RA) &&
		(r_port == PORT_OPER);

	always_comb
	begin
		st_next = st_reg;
		case (st_reg)
			ST_IDLE:
				if (take)
					st_next = ST_DECIDE;
			ST_DECIDE:
				st_next = ST_IDLE;
			default:
				st_next = ST_IDLE;
		endcase
	end

	// the wait clock restarts per head so each entry gets the full window
	assign tmo_next = (q_empty || q_pop) ? 32'h0 : tmo_reg + 32'h1;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_reg  <= ST_IDLE;
			tmo_reg <= 32'h0;
		end
		else
		begin
			st_reg  <= st_next;
			tmo_reg <= tmo_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (take)
		begin
			r_port   <= in_port;
			r_dst    <= in_dst_ip;
			r_src    <= in_src_ip;
			r_hop    <= in_hop;
			r_nxt    <= in_nxt_hdr;
			r_type   <= in_icmp_type;
			r_l2mc   <= in_l2_mcast;
			r_cong   <= in_congested;
			r_tgt    <= in_nd_target;
			r_mac    <= in_nd_mac;
			r_rapfx  <= in_ra_prefix;
			r_raplen <= in_ra_plen;
		end
	end

	// routing table starts empty; each operator advert replaces the default router, and the prefix when its length is nonzero
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			op_pfx_reg     <= 128'h0;
			op_plen_reg    <= 8'h00;
			op_pfx_vld_reg <= 1'b0;
			def_rtr_reg    <= 128'h0;
			def_vld_reg    <= 1'b0;
		end
		else if (ra_learn)
		begin
			def_rtr_reg <= r_src;
			def_vld_reg <= 1'b1;
			if (r_raplen != 8'h00)
			begin
				op_pfx_reg     <= r_rapfx;
				op_plen_reg    <= r_raplen;
				op_pfx_vld_reg <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			loc_valid      <= 1'b0;
			fwd_valid      <= 1'b0;
			err_valid      <= 1'b0;
			ns_valid       <= 1'b0;
			ra_tx_cust     <= 1'b0;
			drop_valid     <= 1'b0;
			dyn_route_oper <= DYN_OPER_RST;
		end
		else
		begin
			loc_valid  <= d_local;
			fwd_valid  <= any_fwd;
			err_valid  <= any_err;
			ns_valid   <= d_enq;
			ra_tx_cust <= rs_cust;
			drop_valid <= any_drop;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			loc_port       <= PORT_CUST;
			loc_icmp_known <= 1'b0;
			fwd_port       <= PORT_CUST;
			fwd_dst_ip     <= 128'h0;
			fwd_dst_mac    <= 48'h0;
			fwd_src_mac    <= 48'h0;
			fwd_hop        <= 8'h00;
			err_port       <= PORT_CUST;
			err_type       <= 8'h00;
			err_code       <= 8'h00;
			err_dst_ip     <= 128'h0;
			ns_port        <= PORT_CUST;
			ns_target      <= 128'h0;
		end
		else
		begin
			if (d_local)
			begin
				loc_port       <= r_port;
				loc_icmp_known <= known;
			end
			if (any_fwd)
			begin
				fwd_port    <= f_port;
				fwd_dst_ip  <= f_dst;
				fwd_dst_mac <= nc_mac;
				fwd_src_mac <= f_smac;
				fwd_hop     <= f_hop;
			end
			if (any_err)
			begin
				err_port   <= e_port;
				err_type   <= e_type;
				err_code   <= e_code;
				err_dst_ip <= e_dst;
			end
			if (d_enq)
			begin
				ns_port   <= out_port;
				ns_target <= nh;
			end
		end
	end
endmodule // ufe_fwd_engine

// File: test/ufe_fwd_monitor.sv
// concurrent checks on the forwarding engine ports
`timescale 1ns/1ps
module ufe_fwd_monitor
	import ufe_pkg::*;
(
	input wire logic         clk,
	input wire logic         resetn,
	input wire logic         in_valid,
	input wire logic         in_ready,
	input wire logic         in_congested,
	input wire logic [127:0] in_dst_ip,
	input wire logic [47:0]  cfg_cust_mac,
	input wire logic [47:0]  cfg_oper_mac,
	input wire logic         loc_valid,
	input wire logic         loc_port,
	input wire logic         fwd_valid,
	input wire logic         fwd_port,
	input wire logic [47:0]  fwd_src_mac,
	input wire logic         err_valid,
	input wire logic         err_port,
	input wire logic [7:0]   err_type,
	input wire logic [7:0]   err_code,
	input wire logic         ns_valid,
	input wire logic         ra_tx_cust,
	input wire logic         drop_valid,
	input wire logic         dyn_route_oper
);
	wire logic take;
	wire logic ll_mc;
	wire logic any_res;
	assign take = in_valid && in_ready;
	assign ll_mc = in_dst_ip[127:120] == MC_BYTE
		&& in_dst_ip[115:112] == SCOPE_LINK;
	assign any_res = loc_valid || fwd_valid || ns_valid || drop_valid;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	dyn_off_a: assert property (!dyn_route_oper)
		else $error("dynamic routing active on operator side");
	answer_a: assert property (take |-> ##2 any_res)
		else $error("no result two cycles after a take");
	one_kind_a: assert property (
		$onehot0({loc_valid, fwd_valid, ns_valid, drop_valid}))
		else $error("two result kinds at once");
	ll_mcast_a: assert property (take && ll_mc && !in_congested
		|-> ##2 loc_valid && !fwd_valid)
		else $error("link-local multicast not kept local");
	congest_a: assert property (take && in_congested
		|-> ##2 drop_valid && !err_valid ##1 !err_valid)
		else $error("error raised for a congestion drop");
	err_drop_a: assert property (
		err_valid |-> drop_valid || $past(drop_valid))
		else $error("error message without a drop");
	time_exc_a: assert property (err_valid && err_type == T_TIMEX
		|-> err_code == C_HOP_EXC)
		else $error("time exceeded with wrong code");
	unr_oper_a: assert property (err_valid && err_type == T_UNREACH
		|-> err_port == PORT_CUST)
		else $error("unreachable sent on operator side");
	oper_mac_a: assert property (fwd_valid && fwd_port == PORT_OPER
		|-> fwd_src_mac == cfg_oper_mac)
		else $error("operator egress with wrong source mac");
	cust_mac_a: assert property (fwd_valid && fwd_port == PORT_CUST
		|-> fwd_src_mac == cfg_cust_mac)
		else $error("customer egress with wrong source mac");
	ra_cust_a: assert property (ra_tx_cust
		|-> loc_valid && loc_port == PORT_CUST)
		else $error("router advert not tied to customer side");
endmodule // ufe_fwd_monitor

bind ufe_fwd_engine ufe_fwd_monitor ufe_fwd_monitor_i (.*);

// File: test/ufe_nbr_node.sv
// neighbor node model: answers a solicitation lat+1 cycles after it
`timescale 1ns/1ps
module ufe_nbr_node
	import ufe_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         resetn,
	input  wire logic         ns_valid,
	input  wire logic [127:0] ns_target,
	input  wire logic         mute,
	input  wire logic [3:0]   lat,
	input  wire logic         na_ack,
	output logic              na_req,
	output logic [127:0]      na_target,
	output logic [47:0]       na_mac
);
	logic [3:0] cnt_reg;
	logic       wait_reg;
	// mute stands for a neighbor that is absent, so resolution must time out
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			{wait_reg, na_req, cnt_reg} <= 6'h00;
			{na_target, na_mac} <= '1;
		end
		else if (ns_valid && !mute)
		begin
			wait_reg <= 1'b1;
			cnt_reg <= lat;
			na_target <= ns_target;
			na_mac <= {16'h0200, ns_target[31:0]};
		end
		else if (wait_reg && cnt_reg != 4'h0)
			cnt_reg <= cnt_reg - 4'h1;
		else if (wait_reg)
		begin
			wait_reg <= 1'b0;
			na_req <= 1'b1;
		end
		else if (na_ack && na_req)
		begin
			// released fields must not keep looking valid
			na_req <= 1'b0;
			na_target <= ~na_target;
			na_mac <= ~na_mac;
		end
	end
endmodule // ufe_nbr_node

// File: test/tb.sv
// self-checking bench: expected-result queue and an output watcher
`timescale 1ns/1ps
module tb
	import ufe_pkg::*;
;
	typedef struct {
		int           k;
		logic         p;
		logic [127:0] ip;
		logic [47:0]  dm;
		logic [47:0]  sm;
		logic [7:0]   h;
		logic         e;
		logic [7:0]   et;
		logic [7:0]   ec;
		logic         kn;
		logic         ra;
	} ufe_exp_t;
	localparam logic [127:0] CIP = 128'h20010db8000100000000000000000001;
	localparam logic [127:0] OIP = 128'h20010db800ff00000000000000000002;
	localparam logic [127:0] CPF = 128'h20010db8000100000000000000000000;
	localparam logic [127:0] RTR = 128'hfe800000000000000000000000000001;
	localparam logic [127:0] FAR = 128'h20010db8009900000000000000000000;
	localparam logic [127:0] LLM = 128'hff020000000000000000000000000001;
	logic         clk, resetn, in_valid, in_ready, in_port, in_l2_mcast;
	logic         in_congested, loc_valid, loc_port, loc_icmp_known, mute;
	logic         fwd_valid, fwd_port, err_valid, err_port, ns_valid, ns_port;
	logic         ra_tx_cust, drop_valid, dyn_route_oper, na_ack, na_req;
	logic [3:0]   lat;
	logic [7:0]   in_hop, in_nxt_hdr, in_icmp_type, in_ra_plen, cfg_cust_plen;
	logic [7:0]   fwd_hop, err_type, err_code, h;
	logic [47:0]  in_nd_mac, cfg_cust_mac, cfg_oper_mac, fwd_dst_mac;
	logic [47:0]  fwd_src_mac, na_mac;
	logic [127:0] in_dst_ip, in_src_ip, in_nd_target, in_ra_prefix;
	logic [127:0] cfg_cust_ip, cfg_oper_ip, cfg_cust_pfx, fwd_dst_ip;
	logic [127:0] err_dst_ip, ns_target, na_target, d;
	int           mismatches, compares;
	ufe_exp_t     q[$];
	ufe_exp_t     e;
	logic [7:0]   tys[12] = '{8'h01, 8'h03, 8'h81, 8'h82, 8'h83, 8'h84,
		8'h85, 8'h86, 8'h87, 8'h88, 8'h8f, 8'hc8};

	ufe_fwd_engine #(.RES_TMO(20)) ufe_fwd_engine_i (.*);
	ufe_nbr_node ufe_nbr_node_i (.*);

	always #25 clk = ~clk;

	function automatic ufe_exp_t xl(logic p, logic kn, logic ra);
		return '{0, p, 0, 0, 0, 0, 0, 0, 0, kn, ra};
	endfunction
	function automatic ufe_exp_t xf(logic p, logic [127:0] ip,
		logic [47:0] dm, logic [47:0] sm, logic [7:0] h);
		return '{1, p, ip, dm, sm, h, 0, 0, 0, 0, 0};
	endfunction
	function automatic ufe_exp_t xn(logic p, logic [127:0] ip);
		return '{2, p, ip, 0, 0, 0, 0, 0, 0, 0, 0};
	endfunction
	function automatic ufe_exp_t xd(logic p, logic [127:0] ip, logic er,
		logic [7:0] et, logic [7:0] ec);
		return '{3, p, ip, 0, 0, 0, er, et, ec, 0, 0};
	endfunction

	task automatic finish_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic bail;
		mismatches++;
		finish_test();
	endtask
	task automatic cmp(string nm, logic [127:0] ex, logic [127:0] got);
		compares++;
		if (got !== ex)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic pkt(logic p, logic [127:0] dst, logic [127:0] src,
		logic [7:0] hp, logic [7:0] ty);
		in_port = p;
		in_dst_ip = dst;
		in_src_ip = src;
		in_hop = hp;
		in_icmp_type = ty;
		in_nxt_hdr = (ty == 8'h00) ? 8'h11 : NXT_ICMP6;
		{in_l2_mcast, in_congested, in_ra_plen} = 10'h000;
		{in_nd_target, in_nd_mac, in_ra_prefix} = '0;
		lat = 4'($urandom);
	endtask
	// valid stays up until the edge that samples ready high
	task automatic offer(ufe_exp_t x);
		int n;
		q.push_back(x);
		in_valid = 1'b1;
		n = 0;
		@(posedge clk);
		while (in_ready !== 1'b1 && n < 50)
		begin
			n++;
			@(posedge clk);
		end
		#1 in_valid = 1'b0;
		if (n == 50)
			bail();
		@(posedge clk);
		#1;
	endtask
	task automatic drain;
		int n;
		for (n = 0; q.size() > 0 && n < 100; n++)
			@(posedge clk);
		if (q.size() > 0)
			bail();
		repeat (3) @(posedge clk);
		#1;
	endtask
	// drain afterwards so the queued packet cannot race the next one
	task automatic answer(logic p, logic [127:0] own, ufe_exp_t fe);
		int n;
		for (n = 0; na_req !== 1'b1 && n < 40; n++)
			@(posedge clk);
		#1;
		if (n == 40)
			bail();
		pkt(p, own, na_target, 8'hff, T_NA);
		in_nd_target = na_target;
		in_nd_mac = na_mac;
		q.push_back(xl(p, 1'b1, 1'b0));
		na_ack = 1'b1;
		offer(fe);
		na_ack = 1'b0;
		drain();
	endtask

	task automatic chk_loc;
		cmp("loc_port", e.p, loc_port);
		cmp("loc_icmp_known", e.kn, loc_icmp_known);
		cmp("ra_tx_cust", e.ra, ra_tx_cust);
	endtask
	task automatic chk_fwd;
		cmp("fwd_port", e.p, fwd_port);
		cmp("fwd_dst_ip", e.ip, fwd_dst_ip);
		cmp("fwd_dst_mac", e.dm, fwd_dst_mac);
		cmp("fwd_src_mac", e.sm, fwd_src_mac);
		cmp("fwd_hop", e.h, fwd_hop);
	endtask
	task automatic chk_ns;
		cmp("ns_port", e.p, ns_port);
		cmp("ns_target", e.ip, ns_target);
	endtask
	task automatic chk_drop;
		logic s;
		s = err_valid;
		if (s !== 1'b1)
		begin
			@(posedge clk);
			#2;
			s = err_valid;
		end
		cmp("err_valid", e.e, s);
		if (e.e)
		begin
			cmp("err_type", e.et, err_type);
			cmp("err_code", e.ec, err_code);
			cmp("err_dst_ip", e.ip, err_dst_ip);
			cmp("err_port", e.p, err_port);
		end
	endtask

	always
	begin
		@(posedge clk);
		#2;
		if (loc_valid | fwd_valid | ns_valid | drop_valid)
		begin
			if (q.size() == 0)
				e.k = -1;
			else
				e = q.pop_front();
			cmp("kind", e.k, loc_valid ? 0 : fwd_valid ? 1 : ns_valid ? 2 : 3);
			case (e.k)
				0: chk_loc();
				1: chk_fwd();
				2: chk_ns();
				3: chk_drop();
				default: ;
			endcase
		end
	end

	initial
	begin
		clk = 1'b0;
		resetn = 1'b0;
		{in_valid, mute, na_ack} = 3'h0;
		mismatches = 0;
		compares = 0;
		void'($urandom(68));
		pkt(PORT_CUST, '0, '0, 8'h00, 8'h00);
		cfg_cust_ip = CIP;
		cfg_oper_ip = OIP;
		cfg_cust_pfx = CPF;
		cfg_cust_plen = 8'h30;
		cfg_cust_mac = {16'h0200, $urandom};
		cfg_oper_mac = {16'h0600, $urandom};
		h = 8'h02 + 8'($urandom % 253);
		d = FAR + $urandom % 4096;
		repeat (2) @(posedge clk);
		#1 resetn = 1'b1;
		pkt(PORT_CUST, CIP, CPF + 5, 8'h40, T_ECHO_RQ);
		offer(xl(PORT_CUST, 1'b1, 1'b0));
		pkt(PORT_CUST, d, CPF + 5, 8'h40, 8'h00);
		offer(xd(PORT_CUST, CPF + 5, 1'b1, T_UNREACH, C_NO_ROUTE));
		for (int i = 0; i < 4; i++)
		begin
			pkt(i == 0, d, (i == 2) ? '0 : CPF + 5, 8'h40,
				(i == 1) ? T_UNREACH : 8'h00);
			in_l2_mcast = (i == 3);
			offer(xd(i == 0, 0, 1'b0, 0, 0));
		end
		pkt(PORT_CUST, CIP, CPF + 5, 8'h40, 8'h00);
		in_congested = 1'b1;
		offer(xd(PORT_CUST, 0, 1'b0, 0, 0));
		for (int i = 0; i < 2; i++)
		begin
			pkt(PORT_CUST, d, CPF + 5, 8'(i), 8'h00);
			offer(xd(PORT_CUST, CPF + 5, 1'b1, T_TIMEX, C_HOP_EXC));
		end
		pkt(PORT_CUST, LLM, CPF + 5, 8'h01, 8'h00);
		offer(xl(PORT_CUST, 1'b0, 1'b0));
		pkt(PORT_CUST, LLM + 1, CPF + 5, 8'hff, T_RS);
		offer(xl(PORT_CUST, 1'b1, 1'b1));
		foreach (tys[i])
		begin
			pkt(PORT_OPER, OIP, RTR, 8'hff, tys[i]);
			{in_ra_prefix, in_ra_plen} = {OIP, 8'h30};
			offer(xl(PORT_OPER, i < 11, 1'b0));
		end
		pkt(PORT_CUST, d, CPF + 5, h, 8'h00);
		offer(xn(PORT_OPER, RTR));
		answer(PORT_OPER, OIP, xf(PORT_OPER, d, {16'h0200, RTR[31:0]},
			cfg_oper_mac, h - 8'h01));
		pkt(PORT_CUST, d + 1, CPF + 6, h, 8'h00);
		offer(xf(PORT_OPER, d + 1, {16'h0200, RTR[31:0]}, cfg_oper_mac,
			h - 8'h01));
		pkt(PORT_OPER, CPF + 7, d, h, 8'h00);
		offer(xn(PORT_CUST, CPF + 7));
		answer(PORT_CUST, CIP, xf(PORT_CUST, CPF + 7, {16'h0200, 32'h7},
			cfg_cust_mac, h - 8'h01));
		mute = 1'b1;
		pkt(PORT_CUST, OIP + 9, CPF + 5, h, 8'h00);
		offer(xn(PORT_OPER, OIP + 9));
		pkt(PORT_CUST, CPF + 8, CPF + 5, h, 8'h00);
		q.push_back(xn(PORT_CUST, CPF + 8));
		q.push_back(xd(PORT_CUST, CPF + 5, 1'b1, T_UNREACH,
			C_ADDR_UNR));
		offer(xd(PORT_CUST, CPF + 5, 1'b1, T_UNREACH, C_ADDR_UNR));
		drain();
		finish_test();
	end
endmodule // tb
